// ---- src/pin_sync.sv ----
// Three-stage synchroniser for pins arriving from outside core_clk.
// Assumes the caller filters by comparing the second and third stages.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         core_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] stage2,
  output logic      [W-1:0] stage3
);
  logic [W-1:0] stage1;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end
endmodule
`default_nettype wire

// ---- src/thermal_limits.sv ----
// Warning and input overvoltage limit commands with their comparators and status flags.
// Assumes telemetry samples arrive on core_clk with a one-cycle valid strobe.
`timescale 1ns/1ps
`default_nettype none
module thermal_limits #(
  parameter logic [6:0] BUS_ADDR = 7'h24,
  parameter logic [5:0] OTW_RESET = thermal_limits_pkg::OTW_NVM,
  parameter logic [3:0] VIN_RESET = thermal_limits_pkg::VIN_NVM
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] die_temp_c,
  input  wire logic       temp_valid,
  input  wire logic [7:0] vin_dv,
  input  wire logic       vin_valid,
  output logic            host_alert_line_n_out,
  output logic            host_alert_line_n_oe,
  output logic            overtemp_warning_flag,
  output logic            input_overvoltage_flag,
  output logic            cml_flag,
  output logic            ivd_flag,
  output logic            switching_enable
);
  thermal_limits_pkg::limit_state_t r;
  thermal_limits_pkg::limit_state_t n;
  logic [1:0] s2;
  logic [1:0] s3;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       clr;
  logic       otw_hit;
  logic       vin_hit;
  logic       rx_done;
  logic [15:0] word;
  logic       bad_otw;
  logic       bad_vin;
  logic [15:0] rd_word;

  // ------------------------------------------------------------
  // Threshold decoding
  // ------------------------------------------------------------
  function automatic logic [7:0] otw_thr(input logic [5:0] m);
    if (m < 6'd25)      otw_thr = 8'd95;
    else if (m < 6'd26) otw_thr = 8'd100;
    else if (m < 6'd27) otw_thr = 8'd105;
    else if (m < 6'd29) otw_thr = 8'd110;
    else if (m < 6'd30) otw_thr = 8'd115;
    else if (m < 6'd31) otw_thr = 8'd120;
    else if (m < 6'd32) otw_thr = 8'd125;
    else                otw_thr = 8'd130;
  endfunction

  function automatic logic [7:0] vin_thr(input logic [3:0] m);
    vin_thr = (m < 4'd9) ? thermal_limits_pkg::VIN_LOW_DV : thermal_limits_pkg::VIN_HI_DV;
  endfunction

  function automatic logic [15:0] read_word(input logic [7:0] c, input logic [5:0] om,
                                            input logic [3:0] vm);
    if (c == thermal_limits_pkg::CMD_OTW)
      read_word = {thermal_limits_pkg::OTW_EXP, 5'h00, om};
    else if (c == thermal_limits_pkg::CMD_VIN_OV)
      read_word = {thermal_limits_pkg::VIN_EXP, 7'h00, vm};
    else
      read_word = 16'h0000;
  endfunction

  pin_sync #(.W(2)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin_in   ({scl_in, sda_in}),
    .stage2   (s2),
    .stage3   (s3)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n        = r;
    scl_rise = (s2[1] == s3[1]) && s3[1] && !r.scl_f;
    scl_fall = (s2[1] == s3[1]) && !s3[1] && r.scl_f;
    start_c  = (s2[0] == s3[0]) && !s3[0] && r.sda_f && r.scl_f && !scl_fall;
    stop_c   = (s2[0] == s3[0]) && s3[0] && !r.sda_f && r.scl_f && !scl_fall;
    if (s2[1] == s3[1]) n.scl_f = s3[1];
    if (s2[0] == s3[0]) n.sda_f = s3[0];
    rx_done  = scl_fall && !r.in_ack && (r.cnt == 4'd8);
    word     = {r.sh, r.lo};
    rd_word  = read_word(r.cmd, r.otw_mant, r.vin_mant);
    bad_otw  = word[15:thermal_limits_pkg::OTW_MSB+1] != {thermal_limits_pkg::OTW_EXP, 5'h00};
    bad_vin  = word[15:thermal_limits_pkg::VIN_MSB+1] != {thermal_limits_pkg::VIN_EXP, 7'h00};
    clr      = 1'b0;
    otw_hit  = temp_valid && (die_temp_c >= otw_thr(r.otw_mant));
    vin_hit  = vin_valid && (vin_dv >= vin_thr(r.vin_mant));

    if (start_c) begin
      n.state   = thermal_limits_pkg::ADDR;
      n.cnt     = 4'd0;
      n.in_ack  = 1'b0;
      n.sda_drv = 1'b0;
    end else if (stop_c) begin
      n.state   = thermal_limits_pkg::IDLE;
      n.sda_drv = 1'b0;
    end else if (r.state == thermal_limits_pkg::RLO || r.state == thermal_limits_pkg::RHI) begin
      if (scl_rise && !r.in_ack) n.cnt = 4'(r.cnt + 4'd1);
      if (scl_rise && r.in_ack && r.sda_f) n.cnt = 4'd15;
      if (scl_fall && !r.in_ack) begin
        if (r.cnt == 4'd8) begin
          n.sda_drv = 1'b0;
          n.in_ack  = 1'b1;
        end else begin
          n.tx      = {r.tx[14:0], 1'b0};
          n.sda_drv = !r.tx[14];
        end
      end else if (scl_fall && r.in_ack) begin
        n.in_ack = 1'b0;
        n.cnt    = 4'd0;
        if (r.state == thermal_limits_pkg::RLO && r.cnt != 4'd15) begin
          n.state   = thermal_limits_pkg::RHI;
          n.tx      = {r.tx[14:0], 1'b0};
          n.sda_drv = !r.tx[14];
        end else begin
          n.state = thermal_limits_pkg::WAIT;
        end
      end
    end else if (r.state != thermal_limits_pkg::IDLE && r.state != thermal_limits_pkg::WAIT) begin
      if (scl_rise && !r.in_ack) begin
        n.sh  = {r.sh[6:0], r.sda_f};
        n.cnt = 4'(r.cnt + 4'd1);
      end
      if (rx_done) begin
        n.in_ack  = 1'b1;
        n.sda_drv = 1'b1;
        unique case (r.state)
          thermal_limits_pkg::ADDR: begin
            if (r.sh[7:1] != BUS_ADDR) begin
              n.state   = thermal_limits_pkg::WAIT;
              n.sda_drv = 1'b0;
            end
          end
          thermal_limits_pkg::CMD: begin
            n.cmd = r.sh;
            clr   = (r.sh == thermal_limits_pkg::CMD_CLEAR);
          end
          thermal_limits_pkg::WLO: n.lo = r.sh;
          thermal_limits_pkg::WHI: begin
            if ((r.cmd == thermal_limits_pkg::CMD_OTW && bad_otw) ||
                (r.cmd == thermal_limits_pkg::CMD_VIN_OV && bad_vin)) begin
              n.sda_drv = 1'b0;
              n.state   = thermal_limits_pkg::WAIT;
              n.cml     = 1'b1;
              n.ivd     = 1'b1;
            end else if (r.cmd == thermal_limits_pkg::CMD_OTW) begin
              n.otw_mant = r.lo[thermal_limits_pkg::OTW_MSB:0];
            end else if (r.cmd == thermal_limits_pkg::CMD_VIN_OV) begin
              n.vin_mant = r.lo[3:0];
            end
          end
          default: ;
        endcase
      end else if (scl_fall && r.in_ack) begin
        n.in_ack  = 1'b0;
        n.cnt     = 4'd0;
        n.sda_drv = 1'b0;
        unique case (r.state)
          thermal_limits_pkg::ADDR: begin
            if (r.sh[0]) begin
              n.state   = thermal_limits_pkg::RLO;
              n.tx      = {rd_word[7:0], rd_word[15:8]};
              n.sda_drv = !rd_word[7];
            end else begin
              n.state = thermal_limits_pkg::CMD;
            end
          end
          thermal_limits_pkg::CMD: n.state = thermal_limits_pkg::WLO;
          thermal_limits_pkg::WLO: n.state = thermal_limits_pkg::WHI;
          default: n.state = thermal_limits_pkg::WAIT;
        endcase
      end
    end

    if (clr) begin
      n.otw_flag = 1'b0;
      n.vin_flag = 1'b0;
      n.cml      = 1'b0;
      n.ivd      = 1'b0;
    end
    if (otw_hit) n.otw_flag = 1'b1;
    if (vin_hit) begin
      n.vin_flag = 1'b1;
      n.sw_en    = 1'b0;
    end
    n.alert = n.otw_flag | n.vin_flag | n.cml;
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r          <= '0;
      r.scl_f    <= 1'b1;
      r.sda_f    <= 1'b1;
      r.otw_mant <= OTW_RESET;
      r.vin_mant <= VIN_RESET;
      r.sw_en    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign sda_out                = 1'b0;
  assign sda_oe                 = r.sda_drv;
  assign host_alert_line_n_out  = 1'b0;
  assign host_alert_line_n_oe   = r.alert;
  assign overtemp_warning_flag  = r.otw_flag;
  assign input_overvoltage_flag = r.vin_flag;
  assign cml_flag               = r.cml;
  assign ivd_flag               = r.ivd;
  assign switching_enable       = r.sw_en;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_otw_detect:  assert property (otw_hit |=> r.otw_flag && host_alert_line_n_oe)
    else $error("warning not flagged");
  chk_otw_sticky:  assert property (r.otw_flag && !clr |=> r.otw_flag)
    else $error("warning flag dropped");
  chk_vin_detect:  assert property (vin_hit |=> r.vin_flag && !r.sw_en)
    else $error("overvoltage not flagged");
  chk_latch_off:   assert property (!r.sw_en |=> !r.sw_en ##1 !r.sw_en)
    else $error("switching restarted");
  chk_alert_level: assert property (r.otw_flag |-> host_alert_line_n_oe)
    else $error("alert not asserted");
  chk_bad_nack:    assert property (rx_done && r.state == thermal_limits_pkg::WHI &&
                                    r.cmd == thermal_limits_pkg::CMD_OTW && bad_otw
                                    |=> !sda_oe && r.ivd && r.cml && $stable(r.otw_mant))
    else $error("bad write not refused");
  chk_good_write:  assert property (rx_done && r.state == thermal_limits_pkg::WHI &&
                                    r.cmd == thermal_limits_pkg::CMD_VIN_OV && !bad_vin
                                    |=> sda_oe && r.vin_mant == $past(r.lo[3:0]))
    else $error("mantissa not stored");
  chk_otw_read:    assert property (scl_fall && r.in_ack && r.state == thermal_limits_pkg::ADDR &&
                                    r.sh[0] && r.cmd == thermal_limits_pkg::CMD_OTW
                                    |=> r.tx == {2'b00, $past(r.otw_mant), 8'h10})
    else $error("warning word wrong");
  chk_vin_read:    assert property (scl_fall && r.in_ack && r.state == thermal_limits_pkg::ADDR &&
                                    r.sh[0] && r.cmd == thermal_limits_pkg::CMD_VIN_OV
                                    |=> r.tx == {4'h0, $past(r.vin_mant), 8'h08})
    else $error("overvoltage word wrong");

  cov_good_write: cover property (rx_done && r.state == thermal_limits_pkg::WHI && !bad_otw);
  cov_read_word:  cover property (r.state == thermal_limits_pkg::RHI);
  cov_vin_fault:  cover property (vin_hit);
endmodule
`default_nettype wire

// ---- src/thermal_limits_pkg.sv ----
// Constants, types and state layout for the thermal and input fault limit block.
// Assumes a PMBus slave front end sampled on core_clk at 40 MHz.
// Summary of operation
// - The overtemperature warning threshold is command 51h, written by Write Word and read by Read Word, in degrees Celsius.
// - Each die temperature sample is compared with the selected warning threshold and a warning is seen once it is reached.
// - A warning sets the overtemperature warning flag and pulls the host alert line low.
// - Bits 15:11 of the warning word read as the fixed exponent 00010b, a 4 degree step.
// - Bits 10:6 of the warning word read as zero and bits 5:0 are a writable mantissa reset from the stored default.
// - Any written mantissa reads back unchanged while the applied threshold is the nearest supported setting.
// - A write changing read-only bits is refused with a NACK, discarded, and sets the communication and invalid-data flags.
// - Warning mantissa below 25 gives 95, 25 gives 100, 26 gives 105, 27-28 give 110, 29 gives 115, 30 gives 120, 31 gives 125, 32-63 give 130.
// - The input overvoltage threshold is command 55h, written by Write Word and read by Read Word, in volts.
// - An input overvoltage fault stops switching and always latches off.
// - An input overvoltage fault sets the input overvoltage flag and pulls the host alert line low.
// - Bits 15:11 of the overvoltage word read as the fixed exponent 00001b, a 2 V step.
// - Bits 10:4 of the overvoltage word read as zero, bits 3:0 are writable with default 1001b, below 9 selects 16.5 V and 9-15 select 18.5 V.
package thermal_limits_pkg;

  localparam logic [7:0] CMD_CLEAR  = 8'h03;
  localparam logic [7:0] CMD_OTW    = 8'h51;
  localparam logic [7:0] CMD_VIN_OV = 8'h55;

  localparam logic [4:0] OTW_EXP    = 5'h02;
  localparam logic [4:0] VIN_EXP    = 5'h01;
  localparam logic [5:0] OTW_NVM    = 6'h22;
  localparam logic [3:0] VIN_NVM    = 4'h9;
  localparam int         OTW_MSB    = 5;
  localparam int         VIN_MSB    = 3;

  localparam logic [7:0] VIN_LOW_DV = 8'hA5;
  localparam logic [7:0] VIN_HI_DV  = 8'hB9;

  typedef enum logic [2:0] {IDLE, ADDR, CMD, WLO, WHI, RLO, RHI, WAIT} bus_state_t;

  typedef struct packed {
    bus_state_t  state;
    logic        in_ack;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  lo;
    logic [7:0]  cmd;
    logic [15:0] tx;
    logic        sda_drv;
    logic        scl_f;
    logic        sda_f;
    logic [5:0]  otw_mant;
    logic [3:0]  vin_mant;
    logic        otw_flag;
    logic        vin_flag;
    logic        cml;
    logic        ivd;
    logic        sw_en;
    logic        alert;
  } limit_state_t;

endpackage

// ---- testbench/pmbus_host_model.sv ----
// Behavioural PMBus host that drives the serial clock and data lines.
// Assumes open-drain lines with pull-ups and a 40 MHz core_clk for timing.
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input  wire logic core_clk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output var logic  scl,
  output wire logic sda
);
  logic drv_low = 1'b0;
  initial scl = 1'b1;
  // ----------------------------------------
  // Wire level and 200 ns bit timing.
  // ----------------------------------------
  assign sda = ~(drv_low | (sda_oe & ~sda_out));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    drv_low <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(3);
    r = sda;
    scl <= 1'b0;
    tick(1);
  endtask
  task automatic start();
    drv_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    drv_low <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    drv_low <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    drv_low <= 1'b0;
    tick(8);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] v,
                            output logic [3:0] acks);
    start();
    put_byte({a, 1'b0}, acks[3]);
    put_byte(c, acks[2]);
    put_byte(v[7:0], acks[1]);
    put_byte(v[15:8], acks[0]);
    stop();
  endtask
  task automatic read_word(input logic [6:0] a, input logic [7:0] c,
                           output logic [15:0] v);
    logic k;
    start();
    put_byte({a, 1'b0}, k);
    put_byte(c, k);
    start();
    put_byte({a, 1'b1}, k);
    get_byte(1'b0, v[7:0]);
    get_byte(1'b1, v[15:8]);
    stop();
  endtask
  task automatic send_byte(input logic [6:0] a, input logic [7:0] c);
    logic k;
    start();
    put_byte({a, 1'b0}, k);
    put_byte(c, k);
    stop();
  endtask
endmodule
`default_nettype wire

// ---- testbench/thermal_limits_test.sv ----
// Self-checking bench for the thermal and input fault limit block.
// Assumes the host model drives the serial lines through pull-ups.
`timescale 1ns/1ps
`default_nettype none
module thermal_limits_test;
  localparam logic [6:0] DEV = 7'h24;
  localparam logic [5:0] WM [11] = '{6'h00, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D,
                                     6'h1E, 6'h1F, 6'h20, 6'h3F};
  localparam logic [7:0] WD [11] = '{8'h5F, 8'h5F, 8'h64, 8'h69, 8'h6E, 8'h6E, 8'h73,
                                     8'h78, 8'h7D, 8'h82, 8'h82};
  localparam logic [3:0] VM [4]  = '{4'h0, 4'h8, 4'h9, 4'hF};
  localparam logic [7:0] VD [4]  = '{thermal_limits_pkg::VIN_LOW_DV, thermal_limits_pkg::VIN_LOW_DV,
                                     thermal_limits_pkg::VIN_HI_DV, thermal_limits_pkg::VIN_HI_DV};
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  die_temp_c = 8'h00;
  logic        temp_valid = 1'b0;
  logic [7:0]  vin_dv = 8'h00;
  logic        vin_valid = 1'b0;
  wire logic   scl, sda, sda_out, sda_oe, al_out, al_oe, otw_f, ov_f, cml_f, ivd_f, sw_en;
  wire logic   host_alert_line_n = ~(al_oe & ~al_out);
  wire logic [5:0] st = {otw_f, ov_f, cml_f, ivd_f, sw_en, host_alert_line_n};
  int          err_total = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [3:0]  acks;
  logic [15:0] rd;
  initial forever #12.5 core_clk = ~core_clk;
  thermal_limits #(.BUS_ADDR(DEV)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .die_temp_c(die_temp_c), .temp_valid(temp_valid),
    .vin_dv(vin_dv), .vin_valid(vin_valid), .host_alert_line_n_out(al_out),
    .host_alert_line_n_oe(al_oe), .overtemp_warning_flag(otw_f),
    .input_overvoltage_flag(ov_f), .cml_flag(cml_f), .ivd_flag(ivd_f),
    .switching_enable(sw_en));
  pmbus_host_model u_host (
    .core_clk(core_clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
  // ----------------------------------------
  // Shared tasks.
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic telem(input logic is_vin, input logic [7:0] x);
    @(posedge core_clk);
    die_temp_c <= x;
    vin_dv <= x;
    temp_valid <= ~is_vin;
    vin_valid <= is_vin;
    @(posedge core_clk);
    temp_valid <= 1'b0;
    vin_valid <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v, input logic [3:0] exp);
    u_host.write_word(DEV, c, v, acks);
    check({12'h000, acks}, {12'h000, exp});
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
    u_host.read_word(DEV, c, rd);
    check(rd, exp);
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    check({10'h000, st}, 16'h0003);
    rdchk(thermal_limits_pkg::CMD_OTW, 16'h1022);
    rdchk(thermal_limits_pkg::CMD_VIN_OV, 16'h0809);
    wr(thermal_limits_pkg::CMD_OTW, 16'h103F, 4'hF);
    rdchk(thermal_limits_pkg::CMD_OTW, 16'h103F);
    u_host.write_word(7'h25, thermal_limits_pkg::CMD_OTW, 16'h1000, acks);
    check({12'h000, acks}, 16'h0000);
    wr(thermal_limits_pkg::CMD_OTW, 16'h183F, 4'hE);
    wr(thermal_limits_pkg::CMD_OTW, 16'h107F, 4'hE);
    wr(thermal_limits_pkg::CMD_VIN_OV, 16'h0819, 4'hE);
    rdchk(thermal_limits_pkg::CMD_OTW, 16'h103F);
    rdchk(thermal_limits_pkg::CMD_VIN_OV, 16'h0809);
    check({10'h000, st}, 16'h000E);
    u_host.send_byte(DEV, thermal_limits_pkg::CMD_CLEAR);
    check({10'h000, st}, 16'h0003);
    for (int i = 0; i < 11; i++) begin
      wr(thermal_limits_pkg::CMD_OTW, {10'h040, WM[i]}, 4'hF);
      telem(1'b0, WD[i] - 8'h01);
      check({15'h0000, otw_f}, 16'h0000);
      telem(1'b0, WD[i]);
      check({10'h000, st}, 16'h0022);
      telem(1'b0, 8'h00);
      check({15'h0000, otw_f}, 16'h0001);
      u_host.send_byte(DEV, thermal_limits_pkg::CMD_CLEAR);
    end
    for (int i = 0; i < 4; i++) begin
      wr(thermal_limits_pkg::CMD_VIN_OV, {12'h080, VM[i]}, 4'hF);
      telem(1'b1, VD[i] - 8'h01);
      check({15'h0000, ov_f}, 16'h0000);
      telem(1'b1, VD[i]);
      check({14'h0000, ov_f, host_alert_line_n}, 16'h0002);
      check({15'h0000, sw_en}, 16'h0000);
      u_host.send_byte(DEV, thermal_limits_pkg::CMD_CLEAR);
    end
    check({10'h000, st}, 16'h0001);
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (6) @(posedge core_clk);
    check({10'h000, st}, 16'h0003);
    rdchk(thermal_limits_pkg::CMD_OTW, 16'h1022);
    end_of_test();
  end
endmodule
`default_nettype wire
